// ==== hw/sam_pkg.sv ====
// constants and types shared by both ends of the split-address bus
package sam_pkg;
   localparam int unsigned ADDR_HALF_W     = 16;
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned UPPER_W         = 16;
   localparam int unsigned CFG_W           = 16;
   localparam int unsigned CFG_SYNC_N_BIT  = 15;   // 1 = asynchronous cycles
   localparam int unsigned CFG_SPLIT_BIT   = 4;    // 1 = split-address mode
   localparam logic [15:0] CFG_RESET_VALUE = 16'h8000;
   localparam logic [15:0] UPPER_RESET     = 16'h0000;
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned ACCESS_MAX_NS   = 96;
   // longest time rounds down, never below one cycle
   localparam int unsigned ACCESS_CYC      = (ACCESS_MAX_NS / CLK_PERIOD_NS) < 1 ? 1
                                             : (ACCESS_MAX_NS / CLK_PERIOD_NS);
   localparam logic [3:0]  ACCESS_CYC_W    = 4'(ACCESS_CYC);
   localparam logic [3:0]  LATENCY_DEFAULT = 4'h3;
   localparam int unsigned ADV_PULSE_CYC   = 1;
   localparam int unsigned GAP_CYC         = 1;

   typedef enum logic [3:0]
   {
      SAM_IDLE  = 4'b0001,
      SAM_SENSE = 4'b0010,
      SAM_DRIVE = 4'b0100,
      SAM_DONE  = 4'b1000
   } sam_dev_state_t;

   typedef enum logic [5:0]
   {
      SAH_IDLE   = 6'b000001,
      SAH_UPPER  = 6'b000010,
      SAH_GAP    = 6'b000100,
      SAH_LOWER  = 6'b001000,
      SAH_READ   = 6'b010000,
      SAH_WRITE  = 6'b100000
   } sam_host_state_t;
endpackage

// ==== hw/sam_bus_if.sv ====
// shared multiplexed bus joining host controller and memory end
`timescale 1ns/1ps
`default_nettype none
interface sam_bus_if;
   logic        address_valid_n;  // low while an address is presented
   logic        read_gate_n;      // high: lower half, low: upper half
   logic        write_n;          // low pulse writes the latched word
   logic [15:0] ad_host_o;
   logic        ad_host_oe;
   logic [15:0] ad_dev_o;
   logic        ad_dev_oe;
   logic        wait_o;           // high = data valid
   logic        wait_oe;
   logic [15:0] ad_bus;
   // resolved bus level; host wins only if both drive (contention)
   assign ad_bus = ad_host_oe ? ad_host_o : (ad_dev_oe ? ad_dev_o : 16'h0000);

   modport host
   (
      output address_valid_n, read_gate_n, write_n, ad_host_o, ad_host_oe,
      input  ad_bus, wait_o, wait_oe
   );
   modport device
   (
      input  address_valid_n, read_gate_n, write_n, ad_bus,
      output ad_dev_o, ad_dev_oe, wait_o, wait_oe
   );
endinterface
`default_nettype wire

// ==== hw/sam_device.sv ====
// memory end: split-address capture, sense start, data and wait drive
// Operation
// - one or two address cycles, upper first
// - lone lower cycle reuses stored upper half
// - sensing starts when lower half latched
// - read gate high lower, low upper
// - single cycle: data driven after gate falls
// - entering split mode clears stored upper
// - wait driven exactly with data lines
// - asynchronous mode: wait always shows valid
// - synchronous mode: valid after latency elapses
// - host pulses strobe once or twice
// - two pulses: gate low then high
// - async access within 96 ns of strobe
// - host restarts pending read once only
// - synchronous mode latches on clock edge
// - strobe may stay low across halves
// - split mode only when config bit 4 set
// - system grounds physical upper address pins
`timescale 1ns/1ps
`default_nettype none
module sam_device
(
   input  wire logic                         i_clk,
   input  wire logic                         i_srst,
   input  wire logic [sam_pkg::CFG_W-1:0]    i_cfg_data,     // configuration word
   input  wire logic                         i_cfg_we,       // one-cycle load pulse
   input  wire logic [sam_pkg::DATA_W-1:0]   i_array_rdata,  // array word at o_addr
   output logic [31:0]                       o_addr,         // full latched address
   output logic                              o_sense_start,  // one-cycle pulse
   output logic                              o_write_stb,    // one-cycle write pulse
   output logic [sam_pkg::DATA_W-1:0]        o_write_data,
   output logic                              o_split_mode,
   output logic                              o_restart_err,  // sticky, second restart seen
   sam_bus_if.device                         bus
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0]  adv_n_s_reg;
   logic [1:0]  gate_n_s_reg;
   logic [1:0]  we_n_s_reg;
   logic [15:0] ad_s1_reg;
   logic [15:0] ad_s2_reg;
   logic        adv_prev_reg;
   logic        we_prev_reg;

   // two flops per pin before any logic reads it
   always_ff @(posedge i_clk)
   begin
      adv_n_s_reg  <= {adv_n_s_reg[0], bus.address_valid_n};
      gate_n_s_reg <= {gate_n_s_reg[0], bus.read_gate_n};
      we_n_s_reg   <= {we_n_s_reg[0], bus.write_n};
      ad_s1_reg    <= bus.ad_bus;
      ad_s2_reg    <= ad_s1_reg;
      adv_prev_reg <= adv_n_s_reg[1];
      we_prev_reg  <= we_n_s_reg[1];
   end

   wire adv_low  = ~adv_n_s_reg[1];
   wire adv_rise = adv_n_s_reg[1] & ~adv_prev_reg;
   wire gate_hi  = gate_n_s_reg[1];
   wire we_rise  = we_n_s_reg[1] & ~we_prev_reg;

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   logic [sam_pkg::CFG_W-1:0] cfg_reg;
   wire async_mode = cfg_reg[sam_pkg::CFG_SYNC_N_BIT];
   wire split_mode = cfg_reg[sam_pkg::CFG_SPLIT_BIT];
   wire split_on   = i_cfg_we & i_cfg_data[sam_pkg::CFG_SPLIT_BIT] & ~split_mode;

   // plain shared mode after reset; split mode only by bit 4
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         cfg_reg <= sam_pkg::CFG_RESET_VALUE;
      else if (i_cfg_we)
         cfg_reg <= i_cfg_data;
   end

   // ----------------------------------------------------------------
   // address capture: strobe edge (async) or clock edge (sync)
   // ----------------------------------------------------------------
   // sync mode samples each clock with the strobe low, so a held strobe
   // latches both halves in consecutive cycles
   wire cap_evt   = async_mode ? adv_rise : adv_low;
   wire cap_upper = cap_evt & ~gate_hi & split_mode;
   wire cap_lower = cap_evt & gate_hi;

   logic [sam_pkg::UPPER_W-1:0]     upper_reg;
   logic [sam_pkg::ADDR_HALF_W-1:0] lower_reg;
   logic                            sync_lower_reg;  // one sync lower per strobe

   wire lower_take = cap_lower & (async_mode | ~sync_lower_reg);

   always_ff @(posedge i_clk)
   begin
      if (i_srst | split_on)
         upper_reg <= sam_pkg::UPPER_RESET;
      else if (cap_upper)
         upper_reg <= ad_s2_reg;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         lower_reg <= '0;
      else if (lower_take)
         lower_reg <= ad_s2_reg;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst | ~adv_low)
         sync_lower_reg <= 1'b0;
      else if (lower_take)
         sync_lower_reg <= 1'b1;
   end

   // in split mode the stored upper half pairs with every lower capture; otherwise the upper half reads zero
   assign o_addr = split_mode ? {upper_reg, lower_reg} : {16'h0000, lower_reg};
   assign o_split_mode = split_mode;

   // ----------------------------------------------------------------
   // sense, access timer and data drive
   // ----------------------------------------------------------------
   sam_pkg::sam_dev_state_t state_reg;
   sam_pkg::sam_dev_state_t state_next;
   logic [3:0]              cnt_reg;
   logic                    restart_reg;     // one restart already used
   logic                    err_reg;
   logic [15:0]             rdata_reg;
   logic                    sense_reg;

   wire [3:0] access_cyc = async_mode ? sam_pkg::ACCESS_CYC_W - 4'h1
                                      : sam_pkg::LATENCY_DEFAULT;
   wire       cnt_done   = (cnt_reg == 4'h0);
   wire       reading    = (state_reg == sam_pkg::SAM_DRIVE);

   // only a lower capture begins a sense; upper-only never does
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         sam_pkg::SAM_IDLE:  if (lower_take) state_next = sam_pkg::SAM_SENSE;
         sam_pkg::SAM_SENSE: if (lower_take) state_next = sam_pkg::SAM_SENSE;
                             else if (cnt_done) state_next = sam_pkg::SAM_DRIVE;
         sam_pkg::SAM_DRIVE: if (lower_take) state_next = sam_pkg::SAM_SENSE;
                             else if (gate_hi) state_next = sam_pkg::SAM_DONE;
         sam_pkg::SAM_DONE:  if (lower_take) state_next = sam_pkg::SAM_SENSE;
         default:            state_next = sam_pkg::SAM_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         state_reg <= sam_pkg::SAM_IDLE;
      else
         state_reg <= state_next;
   end

   // timer reloads on every lower capture, counts down while sensing
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         cnt_reg <= 4'h0;
      else if (lower_take)
         cnt_reg <= access_cyc;
      else if (!cnt_done)
         cnt_reg <= cnt_reg - 4'h1;
   end

   // a second restart before completion is a host fault; flagged, not blocked
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         restart_reg <= 1'b0;
         err_reg     <= 1'b0;
      end
      else if (lower_take && state_reg == sam_pkg::SAM_SENSE)
      begin
         restart_reg <= 1'b1;
         err_reg     <= err_reg | restart_reg;
      end
      else if (state_reg == sam_pkg::SAM_SENSE && cnt_done)
         restart_reg <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         sense_reg <= 1'b0;
         rdata_reg <= '0;
      end
      else
      begin
         sense_reg <= lower_take;
         if (state_reg == sam_pkg::SAM_SENSE && cnt_done)
            rdata_reg <= i_array_rdata;
      end
   end

   // data drives only after the gate falls, once a lower half is held;
   // async mode holds off until sensed data stands, as wait there always claims valid
   wire data_ok  = reading | (~async_mode & (state_reg == sam_pkg::SAM_SENSE));
   wire drive_on = data_ok & ~gate_hi & adv_n_s_reg[1];
   assign bus.ad_dev_o  = rdata_reg;
   assign bus.ad_dev_oe = drive_on;
   assign bus.wait_oe   = drive_on;
   // async: valid whenever driven; sync: only after latency
   assign bus.wait_o    = async_mode ? 1'b1 : reading;
   assign o_sense_start = sense_reg;
   assign o_restart_err = err_reg;

   // write pulse on every write strobe release, whether or not a lower half is held
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_write_stb  <= 1'b0;
         o_write_data <= '0;
      end
      else
      begin
         o_write_stb  <= we_rise;
         if (we_rise)
            o_write_data <= ad_s2_reg;
      end
   end
endmodule
`default_nettype wire

// ==== hw/sam_host.sv ====
// host end: issues split-address read and write cycles on the shared bus
`timescale 1ns/1ps
`default_nettype none
module sam_host
(
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_req,        // one-cycle request pulse
   input  wire logic        i_write,      // 1 = write, 0 = read
   input  wire logic        i_two_cycle,  // 1 = send upper half first
   input  wire logic        i_sync,       // 1 = hold strobe across halves
   input  wire logic [31:0] i_addr,
   input  wire logic [15:0] i_wdata,
   output logic             o_busy,
   output logic             o_done,       // one-cycle pulse
   output logic [15:0]      o_rdata,
   sam_bus_if.host          bus
);
   // ----------------------------------------------------------------
   // pin synchronisers for device answers
   // ----------------------------------------------------------------
   logic [1:0]  wait_s_reg;
   logic [15:0] ad_s1_reg;
   logic [15:0] ad_s2_reg;
   always_ff @(posedge i_clk)
   begin
      wait_s_reg <= {wait_s_reg[0], bus.wait_oe & bus.wait_o};
      ad_s1_reg  <= bus.ad_bus;
      ad_s2_reg  <= ad_s1_reg;
   end

   // ----------------------------------------------------------------
   // cycle sequencer: at most two strobe pulses, upper half first
   // ----------------------------------------------------------------
   sam_pkg::sam_host_state_t state_reg;
   logic [31:0] addr_reg;
   logic [15:0] wdata_reg;
   logic        wr_reg;
   logic        sync_reg;
   logic [2:0]  hold_reg;   // ticks spent in current phase

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_reg <= sam_pkg::SAH_IDLE;
         addr_reg  <= '0;
         wdata_reg <= '0;
         wr_reg    <= 1'b0;
         sync_reg  <= 1'b0;
         hold_reg  <= 3'h0;
         o_done    <= 1'b0;
         o_rdata   <= '0;
      end
      else
      begin
         o_done   <= 1'b0;
         hold_reg <= hold_reg + 3'h1;
         case (state_reg)
            sam_pkg::SAH_IDLE:
               if (i_req)
               begin
                  addr_reg  <= i_addr;
                  wdata_reg <= i_wdata;
                  wr_reg    <= i_write;
                  sync_reg  <= i_sync;
                  hold_reg  <= 3'h0;
                  state_reg <= i_two_cycle ? sam_pkg::SAH_UPPER : sam_pkg::SAH_LOWER;
               end
            sam_pkg::SAH_UPPER:  // gate low, strobe low: upper half
               if (hold_reg == 3'h3)
               begin
                  hold_reg  <= 3'h0;
                  state_reg <= sync_reg ? sam_pkg::SAH_LOWER : sam_pkg::SAH_GAP;
               end
            sam_pkg::SAH_GAP:    // strobe high between pulses
               if (hold_reg == 3'h3)
               begin
                  hold_reg  <= 3'h0;
                  state_reg <= sam_pkg::SAH_LOWER;
               end
            sam_pkg::SAH_LOWER:  // gate high, strobe low: lower half
               if (hold_reg == 3'h3)
               begin
                  hold_reg  <= 3'h0;
                  state_reg <= wr_reg ? sam_pkg::SAH_WRITE : sam_pkg::SAH_READ;
               end
            sam_pkg::SAH_READ:   // gate low; wait for valid, never restart
               if (wait_s_reg[1] && hold_reg == 3'h7)
               begin
                  o_rdata   <= ad_s2_reg;
                  o_done    <= 1'b1;
                  state_reg <= sam_pkg::SAH_IDLE;
               end
               else if (hold_reg == 3'h7)
                  hold_reg <= 3'h7;
            sam_pkg::SAH_WRITE:
               if (hold_reg == 3'h3)
               begin
                  o_done    <= 1'b1;
                  state_reg <= sam_pkg::SAH_IDLE;
               end
            default:
               state_reg <= sam_pkg::SAH_IDLE;
         endcase
      end
   end

   // pin drive decoded from state
   wire in_up  = (state_reg == sam_pkg::SAH_UPPER);
   wire in_lo  = (state_reg == sam_pkg::SAH_LOWER);
   wire in_wr  = (state_reg == sam_pkg::SAH_WRITE);
   // strobe released in last tick so each pulse ends high-low-high
   wire adv_lo = (in_up & (sync_reg | hold_reg != 3'h3)) | (in_lo & hold_reg != 3'h3);
   assign bus.address_valid_n = ~adv_lo;
   assign bus.read_gate_n     = ~(in_up | (state_reg == sam_pkg::SAH_READ));
   assign bus.write_n         = ~(in_wr & hold_reg < 3'h2);
   assign bus.ad_host_o       = in_up ? addr_reg[31:16] : (in_lo ? addr_reg[15:0] : wdata_reg);
   assign bus.ad_host_oe      = in_up | in_lo | in_wr | (state_reg == sam_pkg::SAH_GAP);
   assign o_busy              = (state_reg != sam_pkg::SAH_IDLE);
endmodule
`default_nettype wire

// ==== sim/sam_checker.sv ====
// concurrent checks on the split-address bus between the host and memory ends
`timescale 1ns/1ps
`default_nettype none
module sam_checker
(
   input  wire logic i_clk,
   input  wire logic i_srst,
   input  wire logic address_valid_n,
   input  wire logic read_gate_n,
   input  wire logic write_n,
   input  wire logic ad_host_oe,
   input  wire logic ad_dev_oe,
   input  wire logic wait_o,
   input  wire logic wait_oe
);
   // -----------------------------------------------------------------
   // all checks share the single bus clock and its reset
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_wait_with_data: assert property (wait_oe == ad_dev_oe)
      else $error("wait drive differs from data drive");
   a_no_bus_fight: assert property (ad_dev_oe |-> !ad_host_oe)
      else $error("memory drives while host drives");
   a_drive_after_gate: assert property ($rose(ad_dev_oe) |-> !read_gate_n && !$past(read_gate_n))
      else $error("data driven before read gate fell");
   a_drive_release: assert property ($rose(read_gate_n) |-> ##[0:4] !ad_dev_oe)
      else $error("data lines not released after read gate rose");
   a_drive_holds: assert property (ad_dev_oe ##1 (!read_gate_n && address_valid_n && write_n) |-> ad_dev_oe)
      else $error("data drive dropped while read gate low");
   a_valid_stays: assert property ((wait_oe && wait_o) ##1 wait_oe |-> wait_o)
      else $error("wait lost valid while driven");
   // gate falling with strobe idle marks the data phase of a read
   a_access_time: assert property ($fell(read_gate_n) && address_valid_n && $past(address_valid_n) && write_n
                                   |-> ##[0:16] (wait_oe && wait_o))
      else $error("read data not valid in time");
   a_upper_then_lower: assert property ((!address_valid_n && !read_gate_n) |-> ##[1:20]
                                        (!address_valid_n && read_gate_n))
      else $error("upper half not followed by lower half");
endmodule
`default_nettype wire

// ==== sim/split_address_mux_bus_capture_test.sv ====
// self-checking bench: host and memory ends joined over the split-address bus
`timescale 1ns/1ps
`default_nettype none
module split_address_mux_bus_capture_test;
   typedef struct packed {logic wr; logic [31:0] addr; logic [15:0] data;} sam_note_t;
   logic        clk;
   logic        srst;
   logic [15:0] cfg_data;
   logic        cfg_we;
   wire  [15:0] array_rdata;
   logic [31:0] dev_addr;
   logic        sense_start;
   logic        write_stb;
   logic [15:0] write_data;
   logic        split_mode;
   logic        restart_err;
   logic        req;
   logic        wr;
   logic        two;
   logic        sync;
   logic [31:0] addr;
   logic [15:0] wdata;
   logic        busy;
   logic        done;
   logic [15:0] rdata;
   logic [31:0] rnd;
   logic [15:0] up;
   logic        split;
   logic        async_mode;
   sam_note_t   note;
   sam_note_t   notes[$];
   int          failures;
   int          total_checks;
   int          j;
   int          ops;
   int          senses;

   sam_bus_if bus_if();
   sam_device sam_device_inst(.i_clk(clk), .i_srst(srst), .i_cfg_data(cfg_data), .i_cfg_we(cfg_we),
      .i_array_rdata(array_rdata), .o_addr(dev_addr), .o_sense_start(sense_start), .o_write_stb(write_stb),
      .o_write_data(write_data), .o_split_mode(split_mode), .o_restart_err(restart_err), .bus(bus_if));
   sam_host sam_host_inst(.i_clk(clk), .i_srst(srst), .i_req(req), .i_write(wr), .i_two_cycle(two),
      .i_sync(sync), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata),
      .bus(bus_if));
   sam_checker sam_checker_inst(.i_clk(clk), .i_srst(srst), .address_valid_n(bus_if.address_valid_n),
      .read_gate_n(bus_if.read_gate_n), .write_n(bus_if.write_n), .ad_host_oe(bus_if.ad_host_oe),
      .ad_dev_oe(bus_if.ad_dev_oe), .wait_o(bus_if.wait_o), .wait_oe(bus_if.wait_oe));

   // array model: word depends on both halves, so a wrong upper half shows
   assign array_rdata = dev_addr[31:16] ^ dev_addr[15:0] ^ 16'hA5C3;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   task automatic fail(input string msg);
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
   endtask

   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
         fail(msg);
   endtask

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
         fail(msg);
   endtask

   task automatic stop_test;
      if (failures == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // load a config word; entering split mode restarts the upper half at zero
   task automatic load_cfg(input logic [15:0] v);
      @(posedge clk);
      #1;
      cfg_data = v;
      cfg_we = 1'h1;
      @(posedge clk);
      #1;
      cfg_we = 1'h0;
      if (v[4] && !split)
         up = 16'h0000;
      split = v[4];
      async_mode = v[15];
      @(posedge clk);
      #1;
      cmp16({15'h0000, split_mode}, {15'h0000, split}, "split mode flag wrong");
   endtask

   // one bus operation; the expected address is noted before it starts
   task automatic op(input logic w, input logic t);
      int n;
      @(posedge clk);
      #1;
      rnd = xs(rnd);
      addr = rnd;
      rnd = xs(rnd);
      wdata = rnd[15:0];
      if (t && split)
         up = addr[31:16];
      notes.push_back(sam_note_t'{w, {split ? up : 16'h0000, addr[15:0]}, wdata});
      ops++;
      req = 1'h1;
      wr = w;
      two = t;
      sync = ~async_mode;
      @(posedge clk);
      #1;
      req = 1'h0;
      cmp16({15'h0000, busy}, 16'h0001, "host not busy after request");
      for (n = 0; n < 300 && done !== 1'h1; n++)
      begin
         @(posedge clk);
         #2;
      end
      if (n == 300)
         fail("operation never completed");
      repeat (6) @(posedge clk);
   endtask

   // -----------------------------------------------------------------
   // monitor: results compared against the oldest note
   // -----------------------------------------------------------------
   // a write's result is its strobe, one cycle after the host's done
   always @(negedge clk)
   begin
      if (sense_start === 1'h1)
         senses++;
      if (async_mode && bus_if.wait_oe === 1'h1)
         cmp16({15'h0000, bus_if.wait_o}, 16'h0001, "wait not valid in async mode");
      if (write_stb === 1'h1 || (done === 1'h1 && (notes.size() == 0 || !notes[0].wr)))
      begin
         if (notes.size() == 0)
            fail("result without request");
         else
         begin
            note = notes.pop_front();
            if (write_stb === 1'h1)
            begin
               cmp16({15'h0000, note.wr}, 16'h0001, "write strobe for a read");
               cmp32(dev_addr, note.addr, "write address wrong");
               cmp16(write_data, note.data, "write data wrong");
            end
            else
            begin
               cmp32(dev_addr, note.addr, "read address wrong");
               cmp16(rdata, note.addr[31:16] ^ note.addr[15:0] ^ 16'hA5C3, "read data wrong");
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // clock, watchdog and main sequence
   // -----------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      fail("timeout");
      stop_test();
   end

   initial
   begin
      srst = 1'h1;
      cfg_data = 16'h0000;
      cfg_we = 1'h0;
      req = 1'h0;
      wr = 1'h0;
      two = 1'h0;
      sync = 1'h0;
      addr = 32'h00000000;
      wdata = 16'h0000;
      rnd = 32'h0000DC62;
      up = 16'h0000;
      split = 1'h0;
      async_mode = 1'h1;
      ops = 0;
      senses = 0;
      failures = 0;
      total_checks = 0;
      repeat (12) @(posedge clk);
      #1;
      srst = 1'h0;
      repeat (3) @(posedge clk);
      cmp16({15'h0000, split_mode}, 16'h0000, "split mode set after reset");
      op(1'h0, 1'h1);
      load_cfg(16'h8010);
      cmp16(dev_addr[31:16], 16'h0000, "upper half not cleared");
      // reads and writes, one and two address cycles, async then sync
      for (j = 0; j < 12; j++)
      begin
         if (j == 6)
            load_cfg(16'h0010);
         op(j[1], ~j[0]);
      end
      // leave and re-enter split mode: a stored upper half must clear
      load_cfg(16'h8000);
      load_cfg(16'h8010);
      cmp16(dev_addr[31:16], 16'h0000, "upper half not cleared on re-entry");
      op(1'h0, 1'h0);
      cmp32(senses, ops, "sense starts differ from lower captures");
      cmp16({15'h0000, restart_err}, 16'h0000, "restart flag raised");
      stop_test();
   end
endmodule
`default_nettype wire
